// ### core/menu_access_status_led_control.sv
// Menu gating, lamp drive and APB registers for the lubricator panel
module menu_access_status_led_control #(
    parameter int unsigned HEARTBEAT_CYC = menu_led_pkg::HEARTBEAT_CYC,
    parameter int unsigned TRIG_LONG_CYC = menu_led_pkg::TRIG_LONG_CYC,
    parameter int unsigned FLASH_CYC     = menu_led_pkg::FLASH_CYC,
    parameter int unsigned BLINK_CYC     = menu_led_pkg::BLINK_CYC
) (
    input  wire logic                               core_clk,
    input  wire logic                               resetn,
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [11:0]                        paddr,
    input  wire logic [31:0]                        pwdata,
    input  wire logic [3:0]                         pstrb,
    output logic      [31:0]                        prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    input  wire logic                               keyTouch,
    input  wire logic                               extTrigger,
    input  wire logic [menu_led_pkg::FAULT_W-1:0]   faultFlags,
    input  wire logic                               dispenseActive,
    output menu_led_pkg::lamps_t                    lamps,
    output logic                                    displayFlash,
    output logic                                    strokeReq,
    output logic                                    trigTooLong,
    output logic                                    modeBlink,
    output logic                                    irq
);

    // ==========================================
    // Pin synchronisers
    menu_led_pkg::pin_evt_t pins;

    pin_sync u_key (.clk(core_clk), .resetn(resetn), .pinIn(keyTouch), .level(), .rise(pins.keyRise));
    pin_sync u_trig (.clk(core_clk), .resetn(resetn), .pinIn(extTrigger), .level(pins.trigLevel),
                     .rise(pins.trigRise));

    // ==========================================
    // Register file
    // CTRL: [0] on, [3:1] menu request (write starts request), [5:4] mode, [6] cart 250,
    //       [7] key exit, [8] value confirm, [9] manual dispense, [12:10] prime strokes
    logic [31:0] ctrl_q;
    logic [31:0] mask_q;
    logic [31:0] irqStat_q;
    logic [15:0] strokes_q;
    logic        menuReq_q;
    logic        confirmReq_q;
    logic        manualReq_q;
    logic accessPhase;
    logic wrCtrl;
    logic rdIrq;
    assign accessPhase = psel & penable;
    assign wrCtrl      = accessPhase & pwrite & (paddr == menu_led_pkg::REG_CTRL);
    assign rdIrq       = accessPhase & ~pwrite & (paddr == menu_led_pkg::REG_IRQ_STAT);

    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    function automatic logic mapped(input logic [11:0] a);
        return (a == menu_led_pkg::REG_CTRL) || (a == menu_led_pkg::REG_STATUS) ||
               (a == menu_led_pkg::REG_IRQ_STAT) || (a == menu_led_pkg::REG_IRQ_MASK) ||
               (a == menu_led_pkg::REG_STROKES);
    endfunction : mapped

    // Control register; pulse bits are self clearing
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q       <= menu_led_pkg::CTRL_RESET;
            menuReq_q    <= 1'b0;
            confirmReq_q <= 1'b0;
            manualReq_q  <= 1'b0;
        end else if (wrCtrl) begin
            ctrl_q       <= merge_bytes(ctrl_q, pwdata, pstrb) & 32'hFFFF_FC7F;
            menuReq_q    <= pstrb[0];
            confirmReq_q <= pstrb[1] & pwdata[8];
            manualReq_q  <= pstrb[1] & pwdata[9];
        end else begin
            menuReq_q    <= 1'b0;
            confirmReq_q <= 1'b0;
            manualReq_q  <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mask_q <= menu_led_pkg::MASK_RESET;
        end else if (accessPhase & pwrite & (paddr == menu_led_pkg::REG_IRQ_MASK)) begin
            mask_q <= merge_bytes(mask_q, pwdata, pstrb) & 32'h0000_000F;
        end
    end
    logic        unitOn;
    logic        keyExit;
    logic [2:0]  menuCode;
    logic [1:0]  modeCode;
    logic        externalMode;
    assign unitOn       = ctrl_q[0];
    assign menuCode     = ctrl_q[3:1];
    assign modeCode     = ctrl_q[5:4];
    assign externalMode = (modeCode == menu_led_pkg::MODE_EXTERNAL);
    assign keyExit      = wrCtrl & pstrb[0] & pwdata[7];

    // ==========================================
    // Menu state machine
    menu_led_pkg::menu_sel_t menu_q;
    menu_led_pkg::menu_sel_t menu_d;
    logic                    keySeen_q;
    logic                    denied;
    logic                    granted;

    always_comb begin
        menu_d  = menu_q;
        denied  = 1'b0;
        granted = 1'b0;
        if (keyExit) begin
            menu_d = menu_led_pkg::MENU_NONE;
        end else if (menuReq_q & keySeen_q) begin
            unique case (menuCode)
                3'd1:    granted = ~unitOn;
                3'd2:    granted = ~unitOn;
                3'd3:    granted = unitOn;
                3'd4:    granted = unitOn;
                3'd5:    granted = unitOn;
                default: granted = 1'b0;
            endcase
            denied = ~granted & (menuCode != 3'd0);
            if (granted) begin
                menu_d = menu_led_pkg::menu_sel_t'(menuCode);
            end else if (menuCode == 3'd0) begin
                menu_d = menu_led_pkg::MENU_NONE;
            end
        end else if (menu_q != menu_led_pkg::MENU_NONE &&
                     (menu_q == menu_led_pkg::MENU_OVERVIEW || menu_q == menu_led_pkg::MENU_CONFIG) == unitOn) begin
            menu_d = menu_led_pkg::MENU_NONE;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            menu_q <= menu_led_pkg::MENU_NONE;
        end else begin
            menu_q <= menu_d;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            keySeen_q <= 1'b0;
        end else if (pins.keyRise) begin
            keySeen_q <= 1'b1;
        end else if (keyExit) begin
            keySeen_q <= 1'b0;
        end
    end

    // ==========================================
    // Stroke requests
    logic [2:0]  primeLeft_q;
    logic        primeStart;
    logic        primeStroke;
    assign primeStart  = (menu_q == menu_led_pkg::MENU_PRIMING) & manualReq_q;
    assign primeStroke = (primeLeft_q != 3'd0) & ~dispenseActive & ~strokeReq;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            primeLeft_q <= 3'd0;
        end else if (primeStart) begin
            primeLeft_q <= ctrl_q[12:10];
        end else if (primeStroke) begin
            primeLeft_q <= primeLeft_q - 3'd1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            strokeReq <= 1'b0;
            strokes_q <= 16'h0000;
        end else begin
            strokeReq <= (externalMode & unitOn & pins.trigRise) |
                         ((menu_q == menu_led_pkg::MENU_MANUAL) & manualReq_q) | primeStroke;
            if (strokeReq) begin
                strokes_q <= strokes_q + 16'h0001;
            end
        end
    end

    // ==========================================
    // Timers
    logic [31:0] beatCnt_q;
    logic [31:0] trigCnt_q;
    logic [31:0] flashCnt_q;
    logic [31:0] blinkCnt_q;
    logic [2:0]  flashPhase_q;
    logic        blink_q;
    logic        beatPulse;
    logic [3:0]  faultLevel;
    assign beatPulse = (beatCnt_q < 32'(FLASH_CYC));

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            beatCnt_q <= 32'h0000_0000;
        end else if (!unitOn || beatCnt_q == 32'(HEARTBEAT_CYC - 1)) begin
            beatCnt_q <= 32'h0000_0000;
        end else begin
            beatCnt_q <= beatCnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            trigCnt_q   <= 32'h0000_0000;
            trigTooLong <= 1'b0;
        end else if (!(externalMode & pins.trigLevel)) begin
            trigCnt_q   <= 32'h0000_0000;
            trigTooLong <= 1'b0;
        end else if (trigCnt_q >= 32'(TRIG_LONG_CYC - 1)) begin
            trigTooLong <= 1'b1;
        end else begin
            trigCnt_q <= trigCnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            blinkCnt_q <= 32'h0000_0000;
            blink_q    <= 1'b0;
        end else if (blinkCnt_q == 32'(BLINK_CYC - 1)) begin
            blinkCnt_q <= 32'h0000_0000;
            blink_q    <= ~blink_q;
        end else begin
            blinkCnt_q <= blinkCnt_q + 32'h0000_0001;
        end
    end

    // two flashes on confirm; phases on, off, on, off
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            flashCnt_q   <= 32'h0000_0000;
            flashPhase_q <= 3'd0;
        end else if (confirmReq_q & (menu_q == menu_led_pkg::MENU_EDIT || menu_q == menu_led_pkg::MENU_CONFIG)) begin
            flashCnt_q   <= 32'h0000_0000;
            flashPhase_q <= 3'(2 * menu_led_pkg::ACCEPT_FLASHES);
        end else if (flashPhase_q != 3'd0) begin
            if (flashCnt_q == 32'(FLASH_CYC - 1)) begin
                flashCnt_q   <= 32'h0000_0000;
                flashPhase_q <= flashPhase_q - 3'd1;
            end else begin
                flashCnt_q <= flashCnt_q + 32'h0000_0001;
            end
        end
    end

    // ==========================================
    // Lamps
    logic acceptFlash;
    assign acceptFlash = flashPhase_q[0] == 1'b0 && flashPhase_q != 3'd0;
    // any fault code is an error
    assign faultLevel  = faultFlags;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lamps        <= '0;
            displayFlash <= 1'b0;
            modeBlink    <= 1'b0;
        end else begin
            lamps.red    <= |faultLevel;
            lamps.yellow <= keySeen_q;
            if (flashPhase_q != 3'd0) begin
                lamps.green <= acceptFlash;
            end else if (dispenseActive) begin
                lamps.green <= 1'b1;
            end else if (keySeen_q & (menu_q == menu_led_pkg::MENU_EDIT || menu_q == menu_led_pkg::MENU_CONFIG)) begin
                lamps.green <= 1'b1;
            end else begin
                lamps.green <= unitOn & ~(|faultLevel) & beatPulse;
            end
            displayFlash <= acceptFlash;
            modeBlink    <= externalMode & pins.trigLevel & blink_q;
        end
    end

    // ==========================================
    // Interrupts: set wins over read clear
    logic [3:0] irqEvt;
    assign irqEvt = {flashPhase_q == 3'(2 * menu_led_pkg::ACCEPT_FLASHES) & flashCnt_q == 32'h0000_0000,
                     denied, |faultLevel, trigTooLong};

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irqStat_q <= 32'h0000_0000;
        end else begin
            irqStat_q <= (rdIrq ? 32'h0000_0000 : irqStat_q) | {28'h000_0000, irqEvt};
        end
    end

    assign irq = |(irqStat_q & mask_q);

    // ==========================================
    // APB read path; zero wait states
    always_comb begin
        unique case (paddr)
            menu_led_pkg::REG_CTRL:     prdata = ctrl_q;
            menu_led_pkg::REG_STATUS:   prdata = {19'h0_0000, trigTooLong, faultLevel, lamps,
                                                  keySeen_q, menu_q, unitOn};
            menu_led_pkg::REG_IRQ_STAT: prdata = irqStat_q;
            menu_led_pkg::REG_IRQ_MASK: prdata = mask_q;
            menu_led_pkg::REG_STROKES:  prdata = {16'h0000, strokes_q};
            default:                    prdata = 32'h0000_0000;
        endcase
    end

    assign pready  = 1'b1;
    // writes accepted in on and off alike
    assign pslverr = accessPhase & ~mapped(paddr);

endmodule : menu_access_status_led_control

// ### core/menu_led_pkg.sv
// Package: constants and types for the menu access and status lamp block
package menu_led_pkg;

    // ==========================================
    // Timing
    localparam int unsigned CLK_HZ            = 10_000_000;
    localparam int unsigned HEARTBEAT_S       = 5;
    localparam int unsigned HEARTBEAT_CYC     = CLK_HZ * HEARTBEAT_S;
    localparam int unsigned TRIG_LONG_S       = 15;
    localparam int unsigned TRIG_LONG_CYC     = CLK_HZ * TRIG_LONG_S;
    localparam int unsigned FLASH_MS          = 250;
    localparam int unsigned FLASH_CYC         = (CLK_HZ / 1000) * FLASH_MS;
    localparam int unsigned BLINK_MS          = 500;
    localparam int unsigned BLINK_CYC         = (CLK_HZ / 1000) * BLINK_MS;
    localparam int unsigned ACCEPT_FLASHES    = 2;
    localparam int unsigned STROKE_UL         = 160;

    // ==========================================
    // Field positions and widths
    localparam int unsigned FAULT_CARTRIDGE   = 0;
    localparam int unsigned FAULT_OVERPRESS   = 1;
    localparam int unsigned FAULT_UNDERVOLT   = 2;
    localparam int unsigned FAULT_FATAL       = 3;
    localparam int unsigned FAULT_W           = 4;
    localparam int unsigned IRQ_W             = 4;
    localparam int unsigned IRQ_TRIG_LONG     = 0;
    localparam int unsigned IRQ_FAULT         = 1;
    localparam int unsigned IRQ_DENIED        = 2;
    localparam int unsigned IRQ_ACCEPT        = 3;

    // ==========================================
    // Register offsets (byte addresses)
    localparam logic [11:0] REG_CTRL          = 12'h000;
    localparam logic [11:0] REG_STATUS        = 12'h004;
    localparam logic [11:0] REG_IRQ_STAT      = 12'h008;
    localparam logic [11:0] REG_IRQ_MASK      = 12'h00C;
    localparam logic [11:0] REG_STROKES       = 12'h010;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;
    localparam logic [31:0] MASK_RESET        = 32'h0000_0000;

    typedef enum logic [1:0] {
        MODE_HOURLY,
        MODE_DRAIN,
        MODE_EXTERNAL
    } op_mode_t;

    typedef enum logic [2:0] {
        MENU_NONE,
        MENU_OVERVIEW,
        MENU_CONFIG,
        MENU_MANUAL,
        MENU_EDIT,
        MENU_PRIMING
    } menu_sel_t;

    // Lamps travel together
    typedef struct packed {
        logic red;
        logic yellow;
        logic green;
    } lamps_t;

    // Sync'ed pin events
    typedef struct packed {
        logic keyRise;
        logic trigRise;
        logic trigLevel;
    } pin_evt_t;

endpackage : menu_led_pkg

// ### core/pin_sync.sv
// Two-flop synchroniser with rising edge detect
module pin_sync (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic pinIn,
    output logic      level,
    output logic      rise
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // First flop feeds only the second one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pinIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;

endmodule : pin_sync

// ### testbench/menu_led_checker.sv
// Concurrent checks on the ports of the menu access and status lamp block
module menu_led_checker #(
    parameter int unsigned TRIG_LONG_CYC = 300
) (
    input wire logic                 core_clk,
    input wire logic                 resetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic [11:0]          paddr,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 keyTouch,
    input wire logic                 extTrigger,
    input wire logic [3:0]           faultFlags,
    input wire menu_led_pkg::lamps_t lamps,
    input wire logic                 displayFlash,
    input wire logic                 strokeReq,
    input wire logic                 trigTooLong,
    input wire logic                 modeBlink
);
    // ==========================================
    // Helper counters
    int unsigned trigCnt_q;
    logic [3:0]  keyAge_q;
    logic [3:0]  trigAge_q;
    logic        mapped;
    assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
    // Saturates so a held trigger cannot wrap the count
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            trigCnt_q <= 0;
        end else begin
            trigCnt_q <= !extTrigger ? 0 : (trigCnt_q > TRIG_LONG_CYC ? trigCnt_q : trigCnt_q + 1);
        end
    end
    // Recent pin activity, covers the synchroniser lag
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            keyAge_q  <= 4'h0;
            trigAge_q <= 4'h0;
        end else begin
            keyAge_q  <= keyTouch ? 4'h8 : (keyAge_q != 4'h0 ? keyAge_q - 4'h1 : 4'h0);
            trigAge_q <= extTrigger ? 4'hC : (trigAge_q != 4'h0 ? trigAge_q - 4'h1 : 4'h0);
        end
    end
    // ==========================================
    // Properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence flashOn_s;
        displayFlash [*8];
    endsequence
    reset_dark_a: assert property (!$past(resetn) |-> lamps == '0 && !strokeReq)
        else $error("lamps or stroke active right after reset");
    red_lamp_a: assert property (1'b1 |=> lamps.red == $past(|faultFlags))
        else $error("red lamp does not follow fault flags");
    apb_ready_a: assert property (psel |-> pready)
        else $error("pready low during a transfer");
    slverr_map_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    stroke_pulse_a: assert property (strokeReq |=> !strokeReq)
        else $error("stroke request longer than one cycle");
    trig_long_a: assert property ($rose(trigTooLong) |-> trigCnt_q >= TRIG_LONG_CYC)
        else $error("long trigger flagged too early");
    key_yellow_a: assert property ($rose(lamps.yellow) |-> keyAge_q != 4'h0)
        else $error("yellow lamp without key touch");
    blink_trig_a: assert property ($rose(modeBlink) |-> trigAge_q != 4'h0)
        else $error("mode blink without trigger");
    accept_green_a: assert property (displayFlash |-> lamps.green)
        else $error("display flash without green lamp");
    accept_len_a: assert property ($rose(displayFlash) |-> flashOn_s)
        else $error("acceptance flash too short");
endmodule : menu_led_checker

bind menu_access_status_led_control menu_led_checker #(.TRIG_LONG_CYC(TRIG_LONG_CYC)) i_menu_led_checker (
    .core_clk, .resetn, .psel, .penable, .paddr, .pready, .pslverr, .keyTouch, .extTrigger,
    .faultFlags, .lamps, .displayFlash, .strokeReq, .trigTooLong, .modeBlink);

// ### testbench/panel_partner.sv
// Operator key and external controller stand-in driving the panel pins
module panel_partner (
    input  wire logic core_clk,
    output logic      keyTouch,
    output logic      extTrigger
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        keyTouch   = 1'b0;
        extTrigger = 1'b0;
    end
    // Held long enough to clear the two-flop synchroniser
    task automatic touch_key();
        keyTouch <= 1'b1;
        repeat (4) @(posedge core_clk);
        keyTouch <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask : touch_key
    task automatic set_trig(input logic lvl);
        extTrigger <= lvl;
    endtask : set_trig
    task automatic plc_pulse(input int len);
        extTrigger <= 1'b1;
        repeat (len) @(posedge core_clk);
        extTrigger <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask : plc_pulse
endmodule : panel_partner

// ### testbench/tb.sv
// Self-checking bench for the menu access and status lamp block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] A_CTRL = menu_led_pkg::REG_CTRL;
    localparam logic [11:0] A_STAT = menu_led_pkg::REG_STATUS;
    localparam logic [11:0] A_IRQ  = menu_led_pkg::REG_IRQ_STAT;
    localparam int          HB     = 200;
    localparam int          FL     = 10;
    logic                 core_clk = 1'b0;
    logic                 resetn   = 1'b0;
    logic                 psel     = 1'b0;
    logic                 penable  = 1'b0;
    logic                 pwrite   = 1'b0;
    logic [11:0]          paddr    = 12'h000;
    logic [31:0]          pwdata   = 32'h0000_0000;
    logic [3:0]           pstrb    = 4'hF;
    logic [3:0]           faultFlags = 4'h0;
    logic                 dispenseActive = 1'b0;
    logic [31:0]          prdata, rd;
    logic                 pready, pslverr, keyTouch, extTrigger, displayFlash;
    logic                 strokeReq, trigTooLong, modeBlink, irq, err, pf;
    menu_led_pkg::lamps_t lamps;
    int                   errors = 0, samples_checked = 0, strokes = 0, s0, cnt;

    menu_access_status_led_control #(.HEARTBEAT_CYC(HB), .TRIG_LONG_CYC(300), .FLASH_CYC(FL), .BLINK_CYC(8))
        i_menu_access_status_led_control (.core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .keyTouch, .extTrigger, .faultFlags, .dispenseActive,
        .lamps, .displayFlash, .strokeReq, .trigTooLong, .modeBlink, .irq);
    panel_partner i_panel_partner (.core_clk, .keyTouch, .extTrigger);

    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) if (strokeReq === 1'b1) strokes++;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc
    // Holds the request until pready is seen; release costs one edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb
    // Leave any menu, touch the key, then ask for a menu
    task automatic enter(input logic [31:0] base, input int code);
        apb(1'b1, A_CTRL, base | 32'h0000_0080);
        i_panel_partner.touch_key();
        apb(1'b1, A_CTRL, base | (code << 1));
        cyc(3);
    endtask : enter
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        wrap_up();
    end

    initial begin
        cyc(2);
        resetn <= 1'b1;
        cyc(1);
        chk(lamps, 3'b000);
        apb(1'b0, A_STAT, 32'h0); chk(rd, 32'h0);
        apb(1'b0, A_CTRL, 32'h0); chk(rd, menu_led_pkg::CTRL_RESET);
        apb(1'b0, menu_led_pkg::REG_IRQ_MASK, 32'h0); chk(rd, menu_led_pkg::MASK_RESET);
        apb(1'b0, 12'h020, 32'h0); chk({rd[30:0], err}, 32'h1);
        pstrb <= 4'h1;
        apb(1'b1, A_CTRL, 32'h0000_0F40);
        pstrb <= 4'hF;
        apb(1'b0, A_CTRL, 32'h0); chk(rd, 32'h0000_0040);
        apb(1'b1, A_CTRL, 32'h0000_0002);
        apb(1'b0, A_STAT, 32'h0); chk(rd[3:1], 3'h0);
        apb(1'b0, A_IRQ, 32'h0); chk(rd[2], 1'b0);
        $display("test reset and refusal done");
        // Every menu in both states; refusals are the awkward half
        for (int on = 0; on < 2; on++) begin
            for (int c = 1; c < 6; c++) begin
                enter(on, c);
                apb(1'b0, A_STAT, 32'h0); chk(rd[3:1], ((c < 3) == (on == 0)) ? c : 0);
                chk(rd[6], 1'b1);
                if ((c == 2 && on == 0) || (c == 4 && on == 1)) chk(rd[5], 1'b1);
                apb(1'b0, A_IRQ, 32'h0); chk(rd[2], (c < 3) != (on == 0));
            end
        end
        $display("test menu gating done");
        enter(32'h1, 4);
        apb(1'b1, A_CTRL, 32'h0000_0109);
        cnt = 0;
        pf = 1'b0;
        repeat (6 * FL) begin
            @(posedge core_clk);
            if (displayFlash === 1'b1 && pf === 1'b0) cnt++;
            pf = displayFlash;
        end
        chk(cnt, 2);
        apb(1'b0, A_IRQ, 32'h0); chk(rd[3], 1'b1);
        $display("test acceptance done");
        apb(1'b1, A_CTRL, 32'h0000_0081);
        for (int i = 0; i < 4; i++) begin
            faultFlags <= 4'h1 << i;
            cyc(3);
            chk(lamps.red, 1'b1);
            apb(1'b0, A_STAT, 32'h0); chk(rd[11:8], 4'h1 << i);
            faultFlags <= 4'h0;
            cyc(3);
            chk(lamps.red, 1'b0);
        end
        // A whole number of periods gives an exact count at any phase
        for (int f = 0; f < 2; f++) begin
            faultFlags <= f ? 4'h8 : 4'h0;
            cyc(3);
            cnt = 0;
            repeat (2 * HB) begin
                @(posedge core_clk);
                if (lamps.green === 1'b1) cnt++;
            end
            chk(cnt, f ? 0 : 2 * FL);
        end
        faultFlags <= 4'h0;
        cyc(3);
        chk(irq, 1'b0);
        apb(1'b1, menu_led_pkg::REG_IRQ_MASK, 32'h0000_0002);
        chk(irq, 1'b1);
        apb(1'b0, A_IRQ, 32'h0); chk(rd[1], 1'b1);
        chk(irq, 1'b0);
        dispenseActive <= 1'b1;
        cyc(3);
        chk(lamps.green, 1'b1);
        dispenseActive <= 1'b0;
        $display("test lamps and faults done");
        apb(1'b1, A_CTRL, 32'h0000_00A1);
        s0 = strokes;
        repeat (3) i_panel_partner.plc_pulse(5);
        chk(strokes - s0, 3);
        i_panel_partner.set_trig(1'b1);
        cyc(320);
        chk(trigTooLong, 1'b1);
        i_panel_partner.set_trig(1'b0);
        cyc(8);
        chk(strokes - s0, 4);
        apb(1'b0, A_IRQ, 32'h0); chk(rd[0], 1'b1);
        $display("test external trigger done");
        enter(32'h0000_0C01, 3);
        s0 = strokes;
        apb(1'b1, A_CTRL, 32'h0000_0E07);
        cyc(10);
        chk(strokes - s0, 1);
        enter(32'h0000_0C01, 5);
        s0 = strokes;
        apb(1'b1, A_CTRL, 32'h0000_0E0B);
        cyc(40);
        chk(strokes - s0, 3);
        apb(1'b0, menu_led_pkg::REG_STROKES, 32'h0); chk(rd, strokes);
        $display("test manual and priming done");
        wrap_up();
    end
endmodule : tb
